// ===== rtl/rlpc_top.sv
`timescale 1ns/1ps
module rlpc_top
  import rlpc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reset_pin,
  input wire logic osc_amp_input,
  input rlpc_core_req_s core_req,
  output logic osc_amp_output,
  output logic chip_reset,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic address_latch_strobe,
  output logic program_fetch_strobe_n,
  output logic port0_drive_n,
  output logic port2_addr_sel,
  output logic pulse_force_high,
  output logic [7:0] power_control_register
);

  rlpc_state_s st;
  rlpc_state_s next_st;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic tick;
    logic phase_tick;
    logic wrap;
    logic low_power;
    tick = 1'b0;
    phase_tick = 1'b0;
    wrap = 1'b0;
    low_power = 1'b0;
    next_st = st;

    // Reset pin: two-stage synchroniser, then counted in oscillator periods
    next_st.rst_sync1 = reset_pin;
    next_st.rst_sync2 = st.rst_sync1;

    // Oscillator period seen as a rising edge only, so high/low time is irrelevant
    next_st.osc_prev = osc_amp_input;
    tick = st.osc_en & osc_amp_input & ~st.osc_prev;

    // Divide by two: internal clock edge on every second oscillator period
    if (tick) begin
      next_st.div2 = ~st.div2;
    end
    phase_tick = tick & st.div2;

    // Reset qualification; a short glitch never reaches the core
    if (!st.rst_sync2) begin
      next_st.rst_cnt = 5'h00;
      next_st.chip_reset = 1'b0;
    end else if (tick && st.rst_cnt != RESET_TICKS) begin
      next_st.rst_cnt = st.rst_cnt + 5'h01;
      if (st.rst_cnt + 5'h01 == RESET_TICKS) begin
        next_st.chip_reset = 1'b1;
      end
    end

    // Strobe slot counter, six oscillator periods per address latch pulse
    if (tick) begin
      wrap = (st.slot == ALE_SLOT_LAST);
      next_st.slot = wrap ? 3'h0 : st.slot + 3'h1;
    end

    // One pulse dropped per external data access; a new access wins over the consume
    if (wrap) begin
      next_st.skip_cur = st.skip_pend;
      next_st.skip_pend = 1'b0;
    end
    if (core_req.xdata_access && st.mode == RLPC_RUN) begin
      next_st.skip_pend = 1'b1;
    end

    // Power mode sequencing
    if (st.chip_reset) begin
      next_st.mode = RLPC_RUN;
      next_st.pend_idle = 1'b0;
      next_st.pend_pdown = 1'b0;
      next_st.pwr_ctl = PWRCTL_RESET;
      next_st.osc_en = 1'b1;
      next_st.skip_pend = 1'b0;
    end else begin
      unique case (st.mode)
        RLPC_RUN: begin
          next_st.osc_en = 1'b1;
          if (core_req.pwr_ctl_wr) begin
            next_st.pwr_ctl = core_req.pwr_ctl_wdata;
            next_st.pend_pdown = core_req.pwr_ctl_wdata[PWRCTL_PDOWN_BIT];
            next_st.pend_idle = core_req.pwr_ctl_wdata[PWRCTL_IDLE_BIT];
          end
          // Entry waits for the requesting instruction to finish
          if (core_req.instr_done && st.pend_pdown) begin
            next_st.mode = RLPC_PDOWN;
            next_st.pend_pdown = 1'b0;
            next_st.pend_idle = 1'b0;
            next_st.osc_en = 1'b0;
          end else if (core_req.instr_done && st.pend_idle) begin
            next_st.mode = RLPC_IDLE;
            next_st.pend_idle = 1'b0;
          end
        end
        RLPC_IDLE: begin
          if (core_req.irq_pending) begin
            next_st.mode = RLPC_RUN;
            next_st.pwr_ctl[PWRCTL_IDLE_BIT] = 1'b0;
          end
        end
        RLPC_PDOWN: begin
          // Interrupts are ignored; only the reset pin restarts the oscillator
          next_st.osc_en = st.rst_sync2;
        end
        default: begin
          next_st.mode = RLPC_RUN;
        end
      endcase
    end

    low_power = (next_st.mode != RLPC_RUN);

    // Core clock stops in idle so all core and register state stays put
    next_st.core_clk_en = phase_tick & (next_st.mode == RLPC_RUN);
    // Peripherals keep running in idle; in power-down nothing but RAM is kept
    next_st.periph_clk_en = phase_tick & (next_st.mode != RLPC_PDOWN);

    // Pin states
    unique case (next_st.mode)
      RLPC_IDLE: begin
        next_st.ale = 1'b1;
        next_st.fetch_n = 1'b1;
      end
      RLPC_PDOWN: begin
        next_st.ale = 1'b0;
        next_st.fetch_n = 1'b0;
      end
      default: begin
        next_st.ale = (next_st.slot <= ALE_HI_LAST) & ~next_st.skip_cur;
        next_st.fetch_n = ~(core_req.ext_prog && next_st.slot >= FETCH_LO_FIRST
                            && next_st.slot <= FETCH_LO_LAST);
      end
    endcase
    next_st.pulse_force_high = low_power;
    next_st.port0_drive_n = low_power & core_req.ext_prog;
    next_st.port2_addr_sel = core_req.ext_prog & (next_st.mode != RLPC_PDOWN);

    // Stopped oscillator leaves the amplifier output parked high
    next_st.osc_out = next_st.osc_en ? ~osc_amp_input : 1'b1;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= RLPC_STATE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------------------
  assign osc_amp_output = st.osc_out;
  assign chip_reset = st.chip_reset;
  assign core_clk_en = st.core_clk_en;
  assign periph_clk_en = st.periph_clk_en;
  assign address_latch_strobe = st.ale;
  assign program_fetch_strobe_n = st.fetch_n;
  assign port0_drive_n = st.port0_drive_n;
  assign port2_addr_sel = st.port2_addr_sel;
  assign pulse_force_high = st.pulse_force_high;
  assign power_control_register = st.pwr_ctl;

endmodule

// ===== rtl/rlpc_pkg.sv
// Notes on behaviour
// - Internal clock comes from a divide-by-two stage, so input duty cycle is irrelevant.
// - In normal running the address latch strobe pulses once every six oscillator periods.
// - Each external data memory access drops exactly one address latch strobe pulse.
// - Idle starts after the requesting instruction completes; core stops, peripherals run.
// - Idle keeps processor state, on-chip RAM and all special registers unchanged.
// - Any enabled interrupt ends idle and execution resumes at its service routine.
// - A hardware reset ends idle and restarts the processor as after power-on.
// - Power-down starts after the requesting instruction, then the oscillator stops.
// - In power-down only on-chip RAM contents are guaranteed to be kept.
// - Only a hardware reset ends power-down; interrupts do not.
// - Idle and power-down request bits live in the power control register.
// - Idle holds both strobes at 1, power-down at 0; pulse outputs stay high.
package rlpc_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int OSC_PER_MCYC = 12;
  localparam int RESET_MIN_MCYC = 2;
  localparam logic [4:0] RESET_TICKS = 5'(OSC_PER_MCYC * RESET_MIN_MCYC);
  localparam logic [2:0] ALE_SLOT_LAST = 3'h5;
  localparam logic [2:0] ALE_HI_LAST = 3'h1;
  localparam logic [2:0] FETCH_LO_FIRST = 3'h3;
  localparam logic [2:0] FETCH_LO_LAST = 3'h4;

  // ---------------------------------------------------------------------------
  // Power control register layout
  // ---------------------------------------------------------------------------
  localparam int PWRCTL_IDLE_BIT = 0;
  localparam int PWRCTL_PDOWN_BIT = 1;
  localparam logic [7:0] PWRCTL_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RLPC_RUN = 2'h0,
    RLPC_IDLE = 2'h1,
    RLPC_PDOWN = 2'h3
  } rlpc_mode_e;

  typedef struct packed {
    logic rst_sync1;
    logic rst_sync2;
    logic [4:0] rst_cnt;
    logic chip_reset;
    logic osc_prev;
    logic osc_en;
    logic div2;
    logic [2:0] slot;
    logic skip_pend;
    logic skip_cur;
    rlpc_mode_e mode;
    logic pend_idle;
    logic pend_pdown;
    logic [7:0] pwr_ctl;
    logic core_clk_en;
    logic periph_clk_en;
    logic ale;
    logic fetch_n;
    logic port0_drive_n;
    logic port2_addr_sel;
    logic pulse_force_high;
    logic osc_out;
  } rlpc_state_s;

  typedef struct packed {
    logic pwr_ctl_wr;
    logic [7:0] pwr_ctl_wdata;
    logic instr_done;
    logic irq_pending;
    logic xdata_access;
    logic ext_prog;
  } rlpc_core_req_s;

  localparam rlpc_state_s RLPC_STATE_RESET = '{
    rst_sync1: 1'b0, rst_sync2: 1'b0, rst_cnt: 5'h00, chip_reset: 1'b1,
    osc_prev: 1'b0, osc_en: 1'b1, div2: 1'b0, slot: 3'h0,
    skip_pend: 1'b0, skip_cur: 1'b0, mode: RLPC_RUN,
    pend_idle: 1'b0, pend_pdown: 1'b0, pwr_ctl: PWRCTL_RESET,
    core_clk_en: 1'b0, periph_clk_en: 1'b0, ale: 1'b1, fetch_n: 1'b1,
    port0_drive_n: 1'b0, port2_addr_sel: 1'b0, pulse_force_high: 1'b1,
    osc_out: 1'b1
  };

endpackage

// ===== dv/rlpc_ext.sv
`timescale 1ns/1ps
module rlpc_ext #(
  parameter int HALF = 2,
  parameter int POR_PER = 40
) (
  input wire logic mclk,
  input wire logic osc_amp_output,
  output logic osc_amp_input,
  output logic reset_pin
);
  int ph = 0;
  logic stopped = 1'b0;
  initial begin
    osc_amp_input = 1'b0;
    reset_pin = 1'b1;
    repeat (POR_PER) @(posedge osc_amp_input);
    @(negedge mclk) reset_pin <= 1'b0;
  end
  // Crystal freezes once the amplifier stops following it
  always @(negedge mclk) begin
    if (reset_pin) stopped <= 1'b0;
    else if (osc_amp_input && osc_amp_output) stopped <= 1'b1;
    if (stopped && !reset_pin) osc_amp_input <= 1'b0;
    else if (ph == HALF - 1) begin
      ph <= 0;
      osc_amp_input <= !osc_amp_input;
    end else ph <= ph + 1;
  end
  task automatic hold_reset(input int n);
    @(negedge mclk) reset_pin <= 1'b1;
    repeat (n) @(posedge osc_amp_input);
    @(negedge mclk) reset_pin <= 1'b0;
  endtask
endmodule

// ===== dv/rlpc_asserts.sv
`timescale 1ns/1ps
module rlpc_asserts
  import rlpc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reset_pin,
  input wire logic osc_amp_input,
  input rlpc_core_req_s core_req,
  input wire logic osc_amp_output,
  input wire logic chip_reset,
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe_n,
  input wire logic port0_drive_n,
  input wire logic port2_addr_sel,
  input wire logic pulse_force_high,
  input wire logic [7:0] power_control_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_idle;
    pulse_force_high && address_latch_strobe && !chip_reset;
  endsequence
  sequence s_pdown;
    pulse_force_high && !address_latch_strobe && !chip_reset;
  endsequence
  property p_idle; s_idle |-> !core_clk_en && program_fetch_strobe_n; endproperty
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  property p_pdown;
    s_pdown |-> (osc_amp_output || $past(reset_pin, 3)) && !periph_clk_en &&
      !program_fetch_strobe_n;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down outputs wrong");
  property p_hold;
    s_pdown ##0 !reset_pin |=> chip_reset || (pulse_force_high && !address_latch_strobe);
  endproperty
  a_hold: assert property (p_hold) else $error("power-down left early");
  property p_wake;
    s_idle ##0 (ce && core_req.irq_pending) |=>
      chip_reset || (!pulse_force_high && !power_control_register[0]);
  endproperty
  a_wake: assert property (p_wake) else $error("idle not ended");
  property p_wr;
    ce && core_req.pwr_ctl_wr && !pulse_force_high && !chip_reset |=>
      chip_reset || power_control_register == $past(core_req.pwr_ctl_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_clk; core_clk_en |-> periph_clk_en && !pulse_force_high; endproperty
  a_clk: assert property (p_clk) else $error("core clock out of place");
  property p_rise; $rose(chip_reset) |-> $past(reset_pin, 2); endproperty
  a_rise: assert property (p_rise) else $error("reset without pin");
  property p_fall; !reset_pin [*3] |=> !chip_reset; endproperty
  a_fall: assert property (p_fall) else $error("reset held too long");
  property p_ports;
    pulse_force_high && !chip_reset |-> port0_drive_n == $past(core_req.ext_prog) &&
      port2_addr_sel == ($past(core_req.ext_prog) && address_latch_strobe);
  endproperty
  a_ports: assert property (p_ports) else $error("port state wrong");
endmodule
bind rlpc_top rlpc_asserts u_rlpc_asserts (.mclk, .rst, .ce, .reset_pin, .osc_amp_input,
  .core_req, .osc_amp_output, .chip_reset, .core_clk_en, .periph_clk_en,
  .address_latch_strobe, .program_fetch_strobe_n, .port0_drive_n, .port2_addr_sel,
  .pulse_force_high, .power_control_register);

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rlpc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  rlpc_core_req_s req = '0;
  logic osc_in, osc_out, rpin, crst, cclk, pclk, ale, fetch_n, p0n, p2a, pfh;
  logic [7:0] pwr_ctl;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  time t_rise = 0;
  time gap = 0;
  always #4 mclk = ~mclk;
  rlpc_ext u_rlpc_ext (.mclk, .osc_amp_output(osc_out), .osc_amp_input(osc_in),
    .reset_pin(rpin));
  rlpc_top u_rlpc_top (.mclk, .rst, .ce(1'b1), .reset_pin(rpin), .osc_amp_input(osc_in),
    .core_req(req), .osc_amp_output(osc_out), .chip_reset(crst), .core_clk_en(cclk),
    .periph_clk_en(pclk), .address_latch_strobe(ale), .program_fetch_strobe_n(fetch_n),
    .port0_drive_n(p0n), .port2_addr_sel(p2a), .pulse_force_high(pfh),
    .power_control_register(pwr_ctl));
  always @(posedge ale) begin
    gap = $time - t_rise;
    t_rise = $time;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run needs about 700 cycles
  always @(posedge mclk) if (++cyc == 20000) begin
    err_total++;
    finish_test;
  end
  task automatic wr(input logic [7:0] d);
    @(negedge mclk) req.pwr_ctl_wr = 1'b1;
    req.pwr_ctl_wdata = d;
    @(negedge mclk) req.pwr_ctl_wr = 1'b0;
  endtask
  task automatic done_pulse;
    @(negedge mclk) req.instr_done = 1'b1;
    @(negedge mclk) req.instr_done = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_reset;
    u_rlpc_ext.hold_reset(22);
    chk(crst, 0);
    u_rlpc_ext.hold_reset(26);
    chk(crst, 1);
    repeat (3) @(negedge mclk);
    chk(crst, 0);
  endtask
  task automatic t_ale;
    repeat (2) @(posedge ale);
    // Let the edge monitor update the gap before it is read
    @(negedge mclk);
    chk(8'(gap / 8), 24);
    @(negedge mclk) req.xdata_access = 1'b1;
    @(negedge mclk) req.xdata_access = 1'b0;
    @(posedge ale);
    @(negedge mclk);
    chk(8'(gap / 8), 48);
  endtask
  task automatic t_idle;
    logic cc = 1'b0;
    logic pc = 1'b0;
    req.ext_prog = 1'b1;
    wr(8'h01);
    chk(pwr_ctl, 8'h01);
    done_pulse;
    chk({ale, fetch_n, pfh, p0n, p2a, cclk}, 8'h3E);
    repeat (40) @(negedge mclk) begin
      cc |= cclk;
      pc |= pclk;
    end
    chk({cc, pc}, 8'h01);
    wr(8'h02);
    chk(pwr_ctl, 8'h01);
    req.irq_pending = 1'b1;
    repeat (2) @(negedge mclk);
    req.irq_pending = 1'b0;
    chk({pfh, pwr_ctl[0]}, 0);
  endtask
  task automatic t_pdown;
    req.ext_prog = 1'b0;
    wr(8'h02);
    done_pulse;
    chk({ale, fetch_n, pfh, p0n, p2a, osc_out}, 8'h09);
    req.irq_pending = 1'b1;
    repeat (20) @(negedge mclk);
    req.irq_pending = 1'b0;
    chk({ale, pfh, osc_in, osc_out}, 8'h05);
    u_rlpc_ext.hold_reset(26);
    chk(crst, 1);
    repeat (4) @(negedge mclk);
    chk({crst, pfh, pwr_ctl}, 0);
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    wait (!rpin);
    repeat (4) @(negedge mclk);
    t_reset;
    t_ale;
    t_idle;
    t_pdown;
    finish_test;
  end
endmodule
